/* src/asu_defs.vh */
// register map, field positions, encodings and reset values of the subtract unit
`ifndef ASU_DEFS_VH
`define ASU_DEFS_VH

`define ASU_A_CTRL 8'h00
`define ASU_A_CMD 8'h04
`define ASU_A_LONGW 8'h08
`define ASU_A_DATA 8'h0C
`define ASU_A_ACC 8'h10
`define ASU_A_STAT 8'h14
`define ASU_A_REPT 8'h18
`define ASU_A_PTR 8'h1C
`define ASU_A_PC 8'h20
`define ASU_A_ADDR 8'h24
`define ASU_A_CYC 8'h28
`define ASU_A_AUX 8'h40

`define ASU_F_SXM 0
`define ASU_F_OVM 1
`define ASU_F_PEXT 2
`define ASU_F_OEXT 3
`define ASU_F_SHARE 4
`define ASU_F_P_HI 11
`define ASU_F_P_LO 8
`define ASU_F_D_HI 15
`define ASU_F_D_LO 12

`define ASU_F_FORM_HI 2
`define ASU_F_FORM_LO 0
`define ASU_F_SH_HI 6
`define ASU_F_SH_LO 3
`define ASU_F_SH16 7
`define ASU_F_K_HI 15
`define ASU_F_K_LO 8
`define ASU_F_UPD_HI 18
`define ASU_F_UPD_LO 16
`define ASU_F_NAR_HI 21
`define ASU_F_NAR_LO 19
`define ASU_F_NEN 22

`define ASU_S_CARRY 0
`define ASU_S_OV 1
`define ASU_S_BUSY 2
`define ASU_S_NOREP 3

`define ASU_FM_DIR 3'h0
`define ASU_FM_IND 3'h1
`define ASU_FM_SHORT 3'h2
`define ASU_FM_LONG 3'h3
`define ASU_FM_BORROW 3'h4

`define ASU_U_NONE 3'h0
`define ASU_U_INC 3'h1
`define ASU_U_DEC 3'h2
`define ASU_U_ADD0 3'h3
`define ASU_U_SUB0 3'h4
`define ASU_U_BRADD 3'h5
`define ASU_U_BRSUB 3'h6

`define ASU_RST_CTRL 16'h0000
`define ASU_RST_CARRY 1'b1
`define ASU_RST_PC 16'h0000

`endif

/* src/asu_sub_unit.v */
// accumulator subtract datapath with apb register access
// Functional notes
// - direct/indirect: acc minus memory word shifted left 0..15
// - sixteen-place encoding shifts memory word left by 16
// - short form: unsigned 8-bit, no shift, no sign extension, not repeatable
// - long form: 16-bit second word, shifted, subtracted from acc
// - vacated low bits of shifted operand are zero
// - upper bits sign-extended when sign extend mode set, else zero
// - unshifted-16 subtract: borrow clears carry, no borrow sets it
// - shift-16 subtract: borrow clears carry, otherwise carry unchanged
// - all forms update overflow and carry; saturate mode governs overflow
// - single direct/indirect cycle counts: 1, 2 shared, 1+d, 1+p, 2+d+p
// - repeated: n, n+1 shared, n+nd, n+p, n+1+p+nd
// - short form takes 1 cycle, or 1+p with external program
// - long form is two words, 2 cycles or 2+2p
// - borrow op: acc minus memory word minus inverted carry
// - borrow op ignores sign extension, saturation and flags still apply
// - borrow op: carry cleared on borrow, set otherwise
// - borrow op cycles: 1, 2 shared, 1+d, 1+p, 2+d+p
// - direct address: 7 low bits joined with page pointer
// - optional next pointer index loaded into pointer select after use
// - pointer updates: none, inc, dec, add, sub, bit-reversed add/sub
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "asu_defs.vh"

module asu_sub_unit (
  // clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // status
  output reg BUSY_O
);

  // one-hot engine states; the run bit doubles as the busy flag
  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;

  // widen then shift; shift brings in zeros at the bottom
  function [31:0] asu_shift;
    input [15:0] v;
    input [4:0] s;
    input sx;
    reg [31:0] e;
    begin
      e = sx ? {{16{v[15]}}, v} : {16'h0000, v};
      asu_shift = e << s;
    end
  endfunction

  function [15:0] asu_rev;
    input [15:0] v;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        asu_rev[i] = v[15 - i];
      end
    end
  endfunction

  // indirect forms take the operand address from the selected pointer
  function asu_is_ind;
    input [2:0] fm;
    input b15;
    begin
      asu_is_ind = (fm == `ASU_FM_IND) || (fm == `ASU_FM_BORROW && b15);
    end
  endfunction

  // instruction words; only the long form carries a second word
  function [15:0] asu_words;
    input [2:0] fm;
    begin
      asu_words = (fm == `ASU_FM_LONG) ? 16'h0002 : 16'h0001;
    end
  endfunction

  // pointer update after the address has been used
  function [15:0] asu_ptr;
    input [15:0] a;
    input [15:0] i0;
    input [2:0] code;
    begin
      case (code)
        `ASU_U_INC: asu_ptr = a + 16'h0001;
        `ASU_U_DEC: asu_ptr = a - 16'h0001;
        `ASU_U_ADD0: asu_ptr = a + i0;
        `ASU_U_SUB0: asu_ptr = a - i0;
        `ASU_U_BRADD: asu_ptr = asu_rev(asu_rev(a) + asu_rev(i0));
        `ASU_U_BRSUB: asu_ptr = asu_rev(asu_rev(a) - asu_rev(i0));
        default: asu_ptr = a;
      endcase
    end
  endfunction

  // total cycles of one instruction, repeat included
  function [15:0] asu_cycles;
    input [2:0] fm;
    input [7:0] n;
    input pe;
    input oe;
    input sh;
    input [3:0] p;
    input [3:0] d;
    reg [15:0] nn;
    reg [15:0] pp;
    reg [15:0] dd;
    begin
      nn = {8'h00, n};
      pp = {12'h000, p};
      dd = {12'h000, d};
      if (fm == `ASU_FM_SHORT) begin
        asu_cycles = pe ? 16'h0001 + pp : 16'h0001;
      end else if (fm == `ASU_FM_LONG) begin
        asu_cycles = pe ? 16'h0002 + pp + pp : 16'h0002;
      end else if (n <= 8'h01) begin
        if (oe && pe) asu_cycles = 16'h0002 + dd + pp;
        else if (oe) asu_cycles = 16'h0001 + dd;
        else if (pe) asu_cycles = 16'h0001 + pp;
        else if (sh) asu_cycles = 16'h0002;
        else asu_cycles = 16'h0001;
      end else begin
        if (oe && pe) asu_cycles = nn + 16'h0001 + pp + nn * dd;
        else if (oe) asu_cycles = nn + nn * dd;
        else if (pe) asu_cycles = nn + pp;
        else if (sh) asu_cycles = nn + 16'h0001;
        else asu_cycles = nn;
      end
    end
  endfunction

  // reset release through two flops
  reg rst_meta;
  reg rst_n;
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software visible state
  reg [15:0] ctrl;
  reg [31:0] cmd;
  reg [15:0] longw;
  reg [15:0] data;
  reg [31:0] acc;
  reg carry;
  reg ovf;
  reg norep;
  reg [7:0] rept;
  reg [8:0] page;
  reg [2:0] pointer_select;
  reg [15:0] pc;
  reg [15:0] addr;
  reg [15:0] cyc_taken;
  reg [15:0] aux [0:7];
  // execution state
  reg [1:0] state;
  reg [15:0] cyc_left;
  reg [7:0] reps;

  // fields of the held instruction and the mode bits
  wire [2:0] form = cmd[`ASU_F_FORM_HI:`ASU_F_FORM_LO];
  wire sh16 = cmd[`ASU_F_SH16];
  wire sign_extend_mode = ctrl[`ASU_F_SXM];
  wire saturate_enable = ctrl[`ASU_F_OVM];
  wire [2:0] wform = PWDATA_I[`ASU_F_FORM_HI:`ASU_F_FORM_LO];
  wire busy = state[1];

  // apb decode; write takes effect at the edge where pready is seen
  wire acc_phase = PSEL_I & PENABLE_I;
  wire take = acc_phase & PREADY_O;
  wire [7:0] wa = PADDR_I;
  wire is_aux = (wa[7:5] == 3'h2) && (wa[1:0] == 2'b00);
  wire mapped = is_aux || (wa[1:0] == 2'b00 && wa <= `ASU_A_CYC);
  // every write is refused while the engine runs; writes to the address and cycle registers are always refused
  wire ro_reg = (wa == `ASU_A_ADDR) || (wa == `ASU_A_CYC);
  wire bad = !mapped || (PWRITE_I && (busy || ro_reg));
  // the refusal is judged in the first access cycle and registered;
  // the write edge obeys the same verdict that PSLVERR_O reports, even
  // if the engine went idle in between
  wire do_wr = take & PWRITE_I & ~PSLVERR_O;
  wire start_cmd = do_wr & (wa == `ASU_A_CMD);
  // indirect operand of the current instruction
  wire ind_form = asu_is_ind(form, cmd[`ASU_F_K_HI]);

  // operand address of the current iteration
  reg [15:0] ea;
  reg [31:0] op;
  reg bin;
  reg [32:0] diff;
  reg vflag;
  reg [31:0] res;
  reg next_carry;
  always @* begin
    if (ind_form) begin
      ea = aux[pointer_select];
    end else begin
      ea = {page, cmd[`ASU_F_K_HI - 1:`ASU_F_K_LO]};
    end
    case (form)
      `ASU_FM_SHORT: op = {24'h000000, cmd[`ASU_F_K_HI:`ASU_F_K_LO]};
      `ASU_FM_LONG: op = asu_shift(longw, {1'b0, cmd[`ASU_F_SH_HI:`ASU_F_SH_LO]}, sign_extend_mode);
      `ASU_FM_BORROW: op = {16'h0000, data};
      default: op = sh16 ? asu_shift(data, 5'h10, sign_extend_mode)
        : asu_shift(data, {1'b0, cmd[`ASU_F_SH_HI:`ASU_F_SH_LO]}, sign_extend_mode);
    endcase
    bin = (form == `ASU_FM_BORROW) ? ~carry : 1'b0;
    diff = {1'b0, acc} - {1'b0, op} - {32'h00000000, bin};
    vflag = (acc[31] ^ op[31]) & (diff[31] ^ acc[31]);
    // saturate toward the sign the operands implied
    if (saturate_enable && vflag) begin
      res = acc[31] ? 32'h80000000 : 32'h7FFFFFFF;
    end else begin
      res = diff[31:0];
    end
    if (sh16 && (form == `ASU_FM_DIR || form == `ASU_FM_IND)) begin
      next_carry = diff[32] ? 1'b0 : carry;
    end else begin
      next_carry = ~diff[32];
    end
  end

  // register file and execution engine share one process for single drivers
  integer k;
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `ASU_RST_CTRL;
      cmd <= 32'h00000000;
      longw <= 16'h0000;
      data <= 16'h0000;
      acc <= 32'h00000000;
      carry <= `ASU_RST_CARRY;
      ovf <= 1'b0;
      norep <= 1'b0;
      rept <= 8'h00;
      page <= 9'h000;
      pointer_select <= 3'h0;
      pc <= `ASU_RST_PC;
      addr <= 16'h0000;
      cyc_taken <= 16'h0000;
      state <= S_IDLE;
      cyc_left <= 16'h0000;
      reps <= 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        aux[k] <= 16'h0000;
      end
    end else begin
      case (state)
        S_IDLE: begin
          if (start_cmd) begin
            cmd <= PWDATA_I;
            // program counter steps before any arithmetic
            pc <= pc + asu_words(wform);
            cyc_left <= asu_cycles(wform, rept, ctrl[`ASU_F_PEXT], ctrl[`ASU_F_OEXT],
              ctrl[`ASU_F_SHARE], ctrl[`ASU_F_P_HI:`ASU_F_P_LO],
              ctrl[`ASU_F_D_HI:`ASU_F_D_LO]);
            cyc_taken <= 16'h0000;
            // short and long forms run once whatever the repeat count
            if (wform == `ASU_FM_SHORT || wform == `ASU_FM_LONG || rept <= 8'h01) begin
              reps <= 8'h01;
            end else begin
              reps <= rept;
            end
            norep <= (wform == `ASU_FM_SHORT) && (rept > 8'h01);
            state <= S_RUN;
          end
        end
        S_RUN: begin
          cyc_left <= cyc_left - 16'h0001;
          cyc_taken <= cyc_taken + 16'h0001;
          // iterations fall in the last cycles; wait states come first
          if ({8'h00, reps} >= cyc_left && reps != 8'h00) begin
            reps <= reps - 8'h01;
            acc <= res;
            carry <= next_carry;
            ovf <= ovf | vflag;
            addr <= ea;
            if (ind_form) begin
              aux[pointer_select] <= asu_ptr(aux[pointer_select], aux[0], cmd[`ASU_F_UPD_HI:`ASU_F_UPD_LO]);
              if (cmd[`ASU_F_NEN]) begin
                pointer_select <= cmd[`ASU_F_NAR_HI:`ASU_F_NAR_LO];
              end
            end
          end
          if (cyc_left <= 16'h0001) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      // plain register writes, only accepted while idle
      if (do_wr) begin
        if (is_aux) aux[wa[4:2]] <= PWDATA_I[15:0];
        case (wa)
          `ASU_A_CTRL: ctrl <= PWDATA_I[15:0];
          `ASU_A_LONGW: longw <= PWDATA_I[15:0];
          `ASU_A_DATA: data <= PWDATA_I[15:0];
          `ASU_A_ACC: acc <= PWDATA_I;
          `ASU_A_STAT: begin
            carry <= PWDATA_I[`ASU_S_CARRY];
            if (PWDATA_I[`ASU_S_OV]) ovf <= 1'b0;
            if (PWDATA_I[`ASU_S_NOREP]) norep <= 1'b0;
          end
          `ASU_A_REPT: rept <= PWDATA_I[7:0];
          `ASU_A_PTR: begin
            page <= PWDATA_I[8:0];
            pointer_select <= PWDATA_I[18:16];
          end
          `ASU_A_PC: pc <= PWDATA_I[15:0];
          default: ;
        endcase
      end
    end
  end

  // read mux
  reg [31:0] rd;
  always @* begin
    rd = 32'h00000000;
    if (is_aux) begin
      rd = {16'h0000, aux[wa[4:2]]};
    end else begin
      case (wa)
        `ASU_A_CTRL: rd = {16'h0000, ctrl};
        `ASU_A_CMD: rd = cmd;
        `ASU_A_LONGW: rd = {16'h0000, longw};
        `ASU_A_DATA: rd = {16'h0000, data};
        `ASU_A_ACC: rd = acc;
        `ASU_A_STAT: rd = {28'h0000000, norep, busy, ovf, carry};
        `ASU_A_REPT: rd = {24'h000000, rept};
        `ASU_A_PTR: rd = {13'h0000, pointer_select, 7'h00, page};
        `ASU_A_PC: rd = {16'h0000, pc};
        `ASU_A_ADDR: rd = {16'h0000, addr};
        `ASU_A_CYC: rd = {16'h0000, cyc_taken};
        default: rd = 32'h00000000;
      endcase
    end
  end

  // one wait state per access keeps all apb outputs registered
  // read data is zero outside its cycle so a stale word never leaks
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      BUSY_O <= 1'b0;
    end else begin
      PREADY_O <= acc_phase & ~PREADY_O;
      PSLVERR_O <= acc_phase & ~PREADY_O & bad;
      PRDATA_O <= (acc_phase & ~PREADY_O & ~PWRITE_I) ? rd : 32'h00000000;
      BUSY_O <= (state == S_RUN) ? (cyc_left > 16'h0001) : start_cmd;
    end
  end

endmodule // asu_sub_unit

/* verification/asu_sub_monitor.sv */
// port-level checker for the subtract unit: apb timing and instruction lengths
`timescale 1ns/1ps
module asu_sub_monitor (
  // clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // apb
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  // status
  input wire BUSY_O
);
  reg [15:0] ctrl, rept, need, cnt;
  wire wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & !PSLVERR_O;
  wire go = wr && PADDR_I == 8'h04;
  wire [2:0] fm = PWDATA_I[2:0];
  // short and long forms never repeat, so their count is one
  wire [15:0] n = (rept < 16'h2 || fm == 3'h2 || fm == 3'h3) ? 16'h1 : rept;
  wire [15:0] p = ctrl[2] ? {12'h0, ctrl[11:8]} : 16'h0;
  wire [15:0] d = ctrl[3] ? n * {12'h0, ctrl[15:12]} : 16'h0;
  wire xtra = (ctrl[2] & ctrl[3]) | (ctrl[4] & !ctrl[2] & !ctrl[3]);
  wire [15:0] want = fm == 3'h2 ? 16'h1 + p : fm == 3'h3 ? 16'h2 + p + p
    : n + p + d + {15'h0, xtra};
  // shadow mode word and repeat count, latch the expected length per command
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl <= 16'h0;
      rept <= 16'h0;
      need <= 16'h0;
      cnt <= 16'h0;
    end else begin
      if (wr && PADDR_I == 8'h00) ctrl <= PWDATA_I[15:0];
      if (wr && PADDR_I == 8'h18) rept <= {8'h0, PWDATA_I[7:0]};
      if (go) need <= want;
      cnt <= go ? 16'h0 : cnt + {15'h0, BUSY_O};
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  ready_timing_a: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O && PSEL_I)
    else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside ready");
  busy_start_a: assert property (go && !BUSY_O |=> BUSY_O)
    else $error("busy did not follow command");
  cycle_count_a: assert property ($fell(BUSY_O) |-> cnt == need)
    else $error("busy length differs from cycle count");
  busy_bound_a: assert property (BUSY_O |-> cnt < need)
    else $error("busy overran cycle count");
  short_once_a: assert property (go && fm == 3'h2 && !ctrl[2] |=> BUSY_O ##1 !BUSY_O)
    else $error("short form not one cycle");
  long_two_a: assert property (go && fm == 3'h3 && !ctrl[2] |=> BUSY_O [*2] ##1 !BUSY_O)
    else $error("long form not two cycles");
  cover property (go && fm == 3'h4);
  cover property ($fell(BUSY_O) && need > 16'h5);
  cover property (PSLVERR_O);
endmodule // asu_sub_monitor

bind asu_sub_unit asu_sub_monitor i_mon (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O));

/* verification/asu_sub_unit_tb.sv */
// self-checking bench for the accumulator subtract unit
`timescale 1ns/1ps
module asu_sub_unit_tb;
  reg clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0, we = 1'b0, perr = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0, rd = 32'h0;
  wire [31:0] rdata;
  wire ready, err, busy;
  integer fails = 0, n_tests = 0, cyc = 0, pc = 0, i;
  // pointer after each update code, starting at 300 with index 10
  localparam [111:0] UPD = {16'h031F, 16'h0310, 16'h02F0, 16'h0310, 16'h02FF, 16'h0301, 16'h0300};
  localparam [31:0] RST_A = {8'h00, 8'h10, 8'h18, 8'h20};
  always #5 clk = ~clk;
  asu_sub_unit i_dut (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(sel), .PENABLE_I(en),
    .PWRITE_I(we), .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(rdata), .PREADY_O(ready),
    .PSLVERR_O(err), .BUSY_O(busy));
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // hang guard, far above the roughly 1240 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer; an idle cycle first so select never toggles twice in a step
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      sel <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      en <= 1'b1;
      @(posedge clk);
      while (ready !== 1'b1) @(posedge clk);
      rd = rdata;
      perr = err;
      sel <= 1'b0;
      en <= 1'b0;
    end
  endtask
  // poll status until the engine is idle
  task wt;
    begin
      rd = 32'h4;
      while (rd[2] !== 1'b0) apb(0, 8'h14, 32'h0);
    end
  endtask
  task run(input [31:0] cmd);
    begin
      apb(1, 8'h04, cmd);
      pc = pc + (cmd[2:0] == 3'h3 ? 2 : 1);
      wt;
    end
  endtask
  // load mode, operand, acc and carry, run, then check status, acc and cycles
  task op(input [31:0] ctl, a0, dat, st, cmd, ea, es, ec);
    begin
      apb(1, 8'h00, ctl);
      apb(1, 8'h08, dat);
      apb(1, 8'h0C, dat);
      apb(1, 8'h10, a0);
      apb(1, 8'h14, st | 32'hA);
      run(cmd);
      chk(rd & 32'hB, es);
      apb(0, 8'h10, 32'h0);
      chk(rd, ea);
      apb(0, 8'h28, 32'h0);
      chk(rd, ec);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i = i + 1) begin
      apb(0, RST_A[i*8+:8], 32'h0);
      chk(rd, 32'h0);
    end
    apb(0, 8'h14, 32'h0);
    chk(rd, 32'h1);
    $display("reset test done");
    apb(1, 8'h1C, 32'h8);
    op(0, 'h24, 'h11, 0, 'h5000, 'h13, 1, 1);
    apb(0, 8'h24, 32'h0);
    chk(rd, 32'h450);
    op(0, 9, 4, 0, 'h9, 1, 1, 1);
    op(0, 7, 0, 1, 'h802, 'hFFFFFFFF, 0, 1);
    op(0, 'hFFFF, 'hFFF, 0, 'h23, 'hF, 1, 2);
    op(1, 'h10000, 'h8000, 1, 0, 'h18000, 0, 1);
    op(0, 'h10000, 'h8000, 0, 0, 'h8000, 1, 1);
    op(1, 'h100, 0, 0, 'h8002, 'h80, 1, 1);
    op(0, 'h50000, 2, 0, 'h80, 'h30000, 0, 1);
    op(0, 0, 1, 1, 'h80, 'hFFFF0000, 0, 1);
    op(0, 6, 6, 0, 4, 'hFFFFFFFF, 0, 1);
    op(0, 4, 2, 1, 4, 2, 1, 1);
    op(1, 'h10000, 'h8000, 1, 4, 'h8000, 1, 1);
    op(0, 'h80000000, 1, 0, 0, 'h7FFFFFFF, 3, 1);
    op(2, 'h80000000, 1, 0, 0, 'h80000000, 3, 1);
    op(3, 'h7FFFFFFF, 'hFFFF, 0, 0, 'h7FFFFFFF, 2, 1);
    $display("arithmetic test done");
    op('h10, 0, 0, 0, 0, 0, 1, 2);
    op('h3208, 0, 0, 0, 0, 0, 1, 4);
    op('h320C, 0, 0, 0, 0, 0, 1, 7);
    op('h204, 0, 0, 0, 2, 0, 1, 3);
    op('h204, 0, 0, 0, 3, 0, 1, 6);
    op('h10, 0, 0, 1, 4, 0, 1, 2);
    apb(1, 8'h18, 32'h3);
    op('h10, 10, 2, 0, 0, 4, 1, 4);
    op('h3208, 10, 2, 0, 0, 4, 1, 12);
    op('h320C, 10, 2, 0, 0, 4, 1, 15);
    op(0, 10, 0, 0, 'h202, 8, 9, 1);
    apb(1, 8'h18, 32'h0);
    $display("cycle test done");
    apb(1, 8'h40, 32'h10);
    for (i = 0; i < 7; i = i + 1) begin
      apb(1, 8'h1C, 32'h30008);
      apb(1, 8'h4C, 32'h300);
      run(32'h400001 | (i << 16) | (i << 19));
      apb(0, 8'h24, 32'h0);
      chk(rd, 32'h300);
      apb(0, 8'h4C, 32'h0);
      chk(rd & 32'hFFFF, {16'h0, UPD[i*16+:16]});
      apb(0, 8'h1C, 32'h0);
      chk({29'h0, rd[18:16]}, i);
    end
    $display("pointer test done");
    apb(0, 8'h30, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1, 8'h28, 32'h5);
    chk({31'h0, perr}, 32'h1);
    // a four-cycle instruction keeps the engine busy across the next write
    apb(1, 8'h00, 32'h3208);
    apb(1, 8'h0C, 32'h0);
    apb(1, 8'h10, 32'h100);
    apb(1, 8'h04, 32'h0);
    pc = pc + 1;
    apb(1, 8'h10, 32'h55);
    chk({31'h0, perr}, 32'h1);
    wt;
    apb(0, 8'h10, 32'h0);
    chk(rd, 32'h100);
    apb(0, 8'h20, 32'h0);
    chk(rd, pc);
    $display("refusal test done");
    final_report;
  end
endmodule // asu_sub_unit_tb
